//--- verilog/smc_defines.vh
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH

// ====================================
// boot stream loading
`define SMC_LOAD_WORDS        2
`define SMC_CFG_IDX           0
`define SMC_PLL_IDX           1

// ====================================
// configuration word field positions
`define SMC_REFRESH_LSB       0
`define SMC_REFRESH_MSB       15
`define SMC_BW_BIT            16
`define SMC_SIZE_LSB          17
`define SMC_SIZE_MSB          19

// ====================================
// pll ratio word field positions
`define SMC_CR_LSB            0
`define SMC_CR_MSB            2
`define SMC_SR_BIT            3
`define SMC_CD_BIT            4
`define SMC_CB_BIT            5
`define SMC_SD_BIT            6
`define SMC_SB_BIT            7

// ====================================
// reset values, register offsets and field limits
`define SMC_CFG_RESET         32'h0008_03E8
`define SMC_PLL_RESET         32'h0000_00F0
`define SMC_CFG_OFFSET        2'h0
`define SMC_PLL_OFFSET        2'h1
`define SMC_SIZE_RESERVED     3'h0
`define SMC_SIZE_DEFAULT      3'h4
`define SMC_CR_MAX            3'h4
`define SMC_REFRESH_MIN       16'h0001

`endif

//--- verilog/smc_refresh_timer.v
`timescale 1ns/10ps
`default_nettype none

// ====================================
// refresh interval timer
module smc_refresh_timer #(
  parameter W = 16
) (
  // clock and control
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire         run_i,
  // interval
  input  wire [W-1:0] interval_i,
  // output
  output reg          tick_o
);
  reg [W-1:0] cnt_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (!run_i) begin
        cnt_q <= {W{1'b0}};
      end else if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= interval_i) begin
        cnt_q  <= {W{1'b0}};
        tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

`default_nettype wire

//--- verilog/smc_mem_config.v
`timescale 1ns/10ps
`default_nettype none
`include "smc_defines.vh"

// Function
// - burst at one word per memory clock
// - two or four bank parts, interleave banks
// - power management uses self-refresh power-down
// - graphics part with pin low acts standard
// - minimum 4 MB wide, 2 MB narrow
// - maximum 64 MB wide, 32 MB narrow
// - up to four separately selected ranks; rank_mask_o is held all ones, so every rank is always selected
// - registers loaded from boot stream under reset
// - registers read-only after reset release
// - refresh interval field, default 1000 cycles
// - bus width bit: 0 wide, 1 narrow
// - rank size code 1..7, default 4
// - cpu ratio codes 0..4, others reserved
// - memory ratio bit: 0 twice, 1 thrice
// - pll off and bypass bits reset to one
module smc_mem_config #(
  parameter RANKS = 4
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // boot loader stream
  input  wire        boot_valid_i,
  input  wire [31:0] boot_data_i,
  input  wire        boot_done_i,
  // register read port
  input  wire        rd_i,
  input  wire        wr_i,
  input  wire [1:0]  addr_i,
  output reg  [31:0] rdata_o,
  output reg         rvalid_o,
  // power management
  input  wire        pwr_down_i,
  // memory side status
  output reg         mem_reset_o,
  output reg         refresh_req_o,
  output reg         self_refresh_o,
  output reg         bus_width_select_o,
  output reg  [2:0]  rank_size_o,
  output reg  [RANKS-1:0] rank_mask_o,
  output reg  [2:0]  cpu_clock_ratio_o,
  output reg         memory_clock_ratio_o,
  output reg         cpu_pll_off_o,
  output reg         cpu_pll_bypass_o,
  output reg         sdram_pll_off_o,
  output reg         sdram_pll_bypass_o,
  output reg         cfg_error_o
);
  // ====================================
  // configuration storage
  reg [31:0] memory_config_q;
  reg [31:0] pll_ratios_q;
  reg        loading_q;
  reg [1:0]  load_idx_q;
  wire       tick;

  // the boot strobes come from another clock domain, so sync them
  reg        bv_s1_q, bv_s2_q, bd_s1_q, bd_s2_q, bv_s3_q;
  reg [31:0] bdat_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      bv_s1_q <= 1'b0;
      bv_s2_q <= 1'b0;
      bv_s3_q <= 1'b0;
      bd_s1_q <= 1'b0;
      bd_s2_q <= 1'b0;
      bdat_q  <= 32'h0000_0000;
    end else if (ce_i) begin
      bv_s1_q <= boot_valid_i;
      bv_s2_q <= bv_s1_q;
      bv_s3_q <= bv_s2_q;
      bd_s1_q <= boot_done_i;
      bd_s2_q <= bd_s1_q;
      // data is held stable by the loader while the valid level is up
      if (bv_s2_q && !bv_s3_q) begin
        bdat_q <= boot_data_i;
      end
    end
  end

  wire boot_word = bv_s2_q && !bv_s3_q;

  // ====================================
  // boot loading; registers frozen after release
  always @(posedge clk_i) begin
    if (rst_i) begin
      memory_config_q <= `SMC_CFG_RESET;
      pll_ratios_q    <= `SMC_PLL_RESET;
      loading_q       <= 1'b1;
      load_idx_q      <= 2'h0;
    end else if (ce_i && loading_q) begin
      if (boot_word) begin
        if (load_idx_q == `SMC_CFG_IDX) begin
          memory_config_q <= boot_data_i;
        end else if (load_idx_q == `SMC_PLL_IDX) begin
          pll_ratios_q <= boot_data_i;
        end
        if (load_idx_q < `SMC_LOAD_WORDS) begin
          load_idx_q <= load_idx_q + 2'h1;
        end
      end
      if (bd_s2_q) begin
        loading_q <= 1'b0;
      end
    end
    // wr_i intentionally unused: writes never alter the registers
  end

  // ====================================
  // register reads
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o  <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rvalid_o <= rd_i && !loading_q;
      if (rd_i && !loading_q) begin
        case (addr_i)
          `SMC_CFG_OFFSET: rdata_o <= {12'h000, memory_config_q[19:0]};
          `SMC_PLL_OFFSET: rdata_o <= {24'h00_0000, pll_ratios_q[7:0]};
          default:         rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ====================================
  // decoded configuration outputs
  wire [2:0]  size_f = memory_config_q[`SMC_SIZE_MSB:`SMC_SIZE_LSB];
  wire [15:0] refr_f = memory_config_q[`SMC_REFRESH_MSB:`SMC_REFRESH_LSB];
  wire [2:0]  cr_f   = pll_ratios_q[`SMC_CR_MSB:`SMC_CR_LSB];
  wire        cd_f   = pll_ratios_q[`SMC_CD_BIT];
  wire        cb_f   = pll_ratios_q[`SMC_CB_BIT];
  wire        sd_f   = pll_ratios_q[`SMC_SD_BIT];
  wire        sb_f   = pll_ratios_q[`SMC_SB_BIT];
  wire        bad    = (size_f == `SMC_SIZE_RESERVED) || (cr_f > `SMC_CR_MAX) ||
                       (cd_f && !cb_f) || (sd_f && !sb_f) || (refr_f < `SMC_REFRESH_MIN);

  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_reset_o          <= 1'b1;
      self_refresh_o       <= 1'b0;
      bus_width_select_o   <= 1'b0;
      rank_size_o          <= `SMC_SIZE_DEFAULT;
      rank_mask_o          <= {RANKS{1'b1}};
      cpu_clock_ratio_o    <= 3'h0;
      memory_clock_ratio_o <= 1'b0;
      cpu_pll_off_o        <= 1'b1;
      cpu_pll_bypass_o     <= 1'b1;
      sdram_pll_off_o      <= 1'b1;
      sdram_pll_bypass_o   <= 1'b1;
      cfg_error_o          <= 1'b0;
    end else if (ce_i) begin
      mem_reset_o          <= loading_q;
      self_refresh_o       <= pwr_down_i && !loading_q;
      bus_width_select_o   <= memory_config_q[`SMC_BW_BIT];
      rank_size_o          <= size_f;
      rank_mask_o          <= {RANKS{1'b1}};
      cpu_clock_ratio_o    <= cr_f;
      memory_clock_ratio_o <= pll_ratios_q[`SMC_SR_BIT];
      cpu_pll_off_o        <= cd_f;
      cpu_pll_bypass_o     <= cb_f;
      sdram_pll_off_o      <= sd_f;
      sdram_pll_bypass_o   <= sb_f;
      // flagged for software; the illegal mix is the loader's fault
      cfg_error_o          <= bad && !loading_q;
    end
  end

  // ====================================
  // refresh pacing, stopped with its count cleared during self-refresh since the parts refresh themselves
  smc_refresh_timer #(
    .W (16)
  ) u_refresh (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .run_i      (!loading_q && !pwr_down_i),
    .interval_i (refr_f),
    .tick_o     (tick)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      refresh_req_o <= 1'b0;
    end else if (ce_i) begin
      refresh_req_o <= tick;
    end
  end
endmodule

`default_nettype wire

//--- verification/smc_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// port checks
module smc_chk (
  // inputs
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        rd_i,
  input wire logic [1:0]  addr_i,
  input wire logic        pwr_down_i,
  // outputs
  input wire logic [31:0] rdata_o,
  input wire logic        rvalid_o,
  input wire logic        mem_reset_o,
  input wire logic        refresh_req_o,
  input wire logic        self_refresh_o,
  input wire logic        bus_width_select_o,
  input wire logic [2:0]  rank_size_o,
  input wire logic        cpu_pll_off_o,
  input wire logic        cpu_pll_bypass_o,
  input wire logic        cfg_error_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // reset itself must be seen here, so no disable
  property p_rst; disable iff (1'b0) rst_i |=> mem_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("interface not held in reset");
  property p_rd; rd_i && !mem_reset_o |=> rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_unmap; rvalid_o && $past(addr_i[1]) |-> rdata_o == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !mem_reset_o && !$past(mem_reset_o) |-> $stable(rank_size_o) && $stable(bus_width_select_o); endproperty
  a_hold: assert property (p_hold) else $error("config changed after load");
  property p_pulse; refresh_req_o |=> !refresh_req_o; endproperty
  a_pulse: assert property (p_pulse) else $error("refresh request too long");
  property p_self; !mem_reset_o |=> self_refresh_o == $past(pwr_down_i); endproperty
  a_self: assert property (p_self) else $error("self refresh not following request");
  property p_norf; self_refresh_o && $past(self_refresh_o) && $past(self_refresh_o, 2) |-> !refresh_req_o; endproperty
  a_norf: assert property (p_norf) else $error("refresh during self refresh");
  property p_err; !mem_reset_o && (rank_size_o == 3'h0 || (cpu_pll_off_o && !cpu_pll_bypass_o)) |-> ##[0:2] cfg_error_o;
  endproperty
  a_err: assert property (p_err) else $error("illegal setting not flagged");
endmodule

bind smc_mem_config smc_chk i_chk (.clk_i, .rst_i, .rd_i, .addr_i, .pwr_down_i, .rdata_o, .rvalid_o, .mem_reset_o,
  .refresh_req_o, .self_refresh_o, .bus_width_select_o, .rank_size_o, .cpu_pll_off_o, .cpu_pll_bypass_o, .cfg_error_o);
`default_nettype wire

//--- verification/smc_sdram_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// memory side: counts refreshes and their spacing
module smc_sdram_model (
  input  wire logic        clk_i,
  input  wire logic        refresh_req_i,
  output var  logic [15:0] gap_o,
  output var  logic [15:0] count_o
);
  logic [15:0] run_q = 16'h0000;
  initial begin
    gap_o = 16'h0000;
    count_o = 16'h0000;
  end
  // pulses in self refresh are counted too, so the bench sees them as faults
  always @(posedge clk_i) begin
    run_q <= run_q + 16'h0001;
    if (refresh_req_i) begin
      gap_o <= run_q + 16'h0001;
      run_q <= 16'h0000;
      count_o <= count_o + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// bench top
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        boot_valid_i = 1'b0;
  logic        boot_done_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        pwr_down_i = 1'b0;
  logic [1:0]  addr_i = 2'h0;
  logic [31:0] boot_data_i = 32'h0000_0000;
  wire  [31:0] rdata_o;
  wire  [15:0] gap, cnt;
  wire  [2:0]  rank_size_o, cpu_clock_ratio_o;
  wire         rvalid_o, mem_reset_o, refresh_req_o, self_refresh_o, bus_width_select_o, cfg_error_o;
  wire         memory_clock_ratio_o, cpu_pll_off_o, cpu_pll_bypass_o, sdram_pll_off_o, sdram_pll_bypass_o;
  int          failures = 0;
  int          tests_run = 0;
  int          n;
  always #12.5 clk_i = ~clk_i;
  smc_mem_config i_dut (.clk_i, .rst_i, .ce_i(1'b1), .boot_valid_i, .boot_data_i, .boot_done_i, .rd_i, .wr_i,
    .addr_i, .rdata_o, .rvalid_o, .pwr_down_i, .mem_reset_o, .refresh_req_o, .self_refresh_o, .bus_width_select_o,
    .rank_size_o, .rank_mask_o(), .cpu_clock_ratio_o, .memory_clock_ratio_o, .cpu_pll_off_o, .cpu_pll_bypass_o,
    .sdram_pll_off_o, .sdram_pll_bypass_o, .cfg_error_o);
  smc_sdram_model i_mem (.clk_i, .refresh_req_i(refresh_req_o), .gap_o(gap), .count_o(cnt));
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // word order is fixed: configuration first, pll ratios second
  task automatic boot(input logic [31:0] c, input logic [31:0] p, input int w);
    rst_i = 1'b1;
    boot_done_i = 1'b0;
    cyc(4);
    rst_i = 1'b0;
    for (int i = 0; i < w; i++) begin
      boot_data_i = (i == 0) ? c : p;
      boot_valid_i = 1'b1;
      cyc(4);
      boot_valid_i = 1'b0;
      cyc(4);
    end
    rd_i = 1'b1;
    cyc(1);
    rd_i = 1'b0;
    chk(rvalid_o, 1'b0);
    chk(mem_reset_o, 1'b1);
    boot_done_i = 1'b1;
    n = 0;
    while (mem_reset_o !== 1'b0 && n < 50) begin
      cyc(1);
      n++;
    end
    if (n == 50) begin
      failures++;
      summarize;
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    addr_i = a;
    rd_i = 1'b1;
    cyc(1);
    chk(rvalid_o, 1'b1);
    chk(rdata_o, exp);
    // a clock edge with the request low keeps back-to-back calls from retoggling rd_i at once
    rd_i = 1'b0;
    cyc(1);
  endtask
  initial begin
    boot(32'h000B_0008, 32'h0000_000C, 2);
    rd(2'h0, 32'h000B_0008);
    rd(2'h1, 32'h0000_000C);
    rd(2'h3, 32'h0000_0000);
    wr_i = 1'b1;
    cyc(1);
    wr_i = 1'b0;
    rd(2'h0, 32'h000B_0008);
    chk({bus_width_select_o, rank_size_o, cpu_clock_ratio_o, memory_clock_ratio_o}, 32'h0000_00D9);
    chk({cpu_pll_off_o, cpu_pll_bypass_o, sdram_pll_off_o, sdram_pll_bypass_o, cfg_error_o}, 32'h0);
    cyc(40);
    chk(gap, 32'h0000_0008);
    pwr_down_i = 1'b1;
    cyc(3);
    n = cnt;
    cyc(30);
    chk(cnt, n);
    chk(self_refresh_o, 1'b1);
    pwr_down_i = 1'b0;
    boot(32'h0000_0000, 32'h0000_0000, 0);
    rd(2'h0, 32'h0008_03E8);
    rd(2'h1, 32'h0000_00F0);
    boot(32'h000E_03E8, 32'h0000_0000, 2);
    chk({bus_width_select_o, rank_size_o, cfg_error_o}, 32'h0000_000E);
    boot(32'h000C_03E8, 32'h0000_0000, 2);
    chk({bus_width_select_o, rank_size_o, cfg_error_o}, 32'h0000_000C);
    boot(32'h0000_0010, 32'h0000_0010, 2);
    chk({bus_width_select_o, rank_size_o, cfg_error_o}, 32'h0000_0001);
    summarize;
  end
endmodule
`default_nettype wire
